// ===== include/stage_pkg.sv
// shared constants and types for the programmable threshold stage bank
package stage_pkg;
  // ==========================================================
  // sizes and timing
  localparam int NSTG = 10; // number of stages
  localparam int NGRP = 8; // number of setting groups
  localparam int CLK_HZ = 25_000_000; // ref_clk rate
  localparam int STAMP_MS = 1; // time stamp resolution in ms
  localparam int MS_CYCLES = CLK_HZ / 1000 * STAMP_MS; // cycles per stamp
  localparam logic [2:0] CYCLE_MS = 3'h5; // evaluation period in ms
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_SEL = 8'h08;
  localparam logic [7:0] A_CFG = 8'h0c;
  localparam logic [7:0] A_THR1 = 8'h10;
  localparam logic [7:0] A_THR2 = 8'h14;
  localparam logic [7:0] A_THR3 = 8'h18;
  localparam logic [7:0] A_DLY = 8'h1c;
  localparam logic [7:0] A_SSTAT = 8'h20;
  localparam logic [7:0] A_OPT = 8'h24;
  localparam logic [7:0] A_CSTART = 8'h28;
  localparam logic [7:0] A_CTRIP = 8'h2c;
  localparam logic [7:0] A_CBLK = 8'h30;
  // ==========================================================
  // field positions and reset values
  localparam int CTL_FRC = 4; // forcing permitted
  localparam int CTL_GRP = 5; // active group, 3 bits
  localparam int CTL_CLR = 8; // counter clear, write-one pulse
  localparam int CTL_MODE = 16; // operating mode, 3 bits
  localparam int CF_EN = 0; // stage enable
  localparam int CF_FRC = 1; // force select, 2 bits
  localparam int CF_MCNT = 3; // magnitude count, 2 bits
  localparam int CF_HND = 5; // handling code, 3 bits
  localparam int CF_KIND = 8; // pick-up kind, 2 bits
  localparam int CF_DLY = 10; // 1 = time-delayed mode
  localparam int CF_CH1 = 11; // channel selects, 3 bits each
  localparam int CF_CH2 = 14;
  localparam int CF_CH3 = 17;
  localparam logic [3:0] AVAIL_RST = 4'h1; // stages available
  localparam logic [2:0] MODE_ON = 3'h1;
  localparam logic [2:0] MODE_BLK = 3'h2;
  localparam logic [2:0] MODE_TST = 3'h3;
  localparam logic [2:0] MODE_TBLK = 3'h4;
  localparam logic [2:0] MODE_OFF = 3'h5;
  localparam logic [1:0] KIND_OVER = 2'h0;
  localparam logic [1:0] KIND_UNDER = 2'h1;
  localparam logic [1:0] KIND_RATE = 2'h2;
  localparam logic [2:0] COND_DIS = 3'h0;
  localparam logic [2:0] COND_IDLE = 3'h1;
  localparam logic [2:0] COND_START = 3'h2;
  localparam logic [2:0] COND_TRIP = 3'h3;
  localparam logic [2:0] COND_BLK = 3'h4;
  // sweep machine over the stages
  typedef enum logic [1:0] {SW_IDLE = 2'b01, SW_RUN = 2'b10} sweep_t;
endpackage

// ===== include/stage_link_if.sv
// link between the stage bank, its combiner and its time base
`timescale 1ns/1ps
interface stage_link_if;
  logic [15:0] m1, m2, m3; // selected magnitudes
  logic [15:0] t1, t2, t3; // thresholds of the active group
  logic [15:0] prev; // last combined value of this stage
  logic [1:0] cnt; // magnitude count select
  logic [1:0] kind; // pick-up kind
  logic [2:0] hand; // handling code
  logic [15:0] value; // combined value
  logic pick; // pick-up condition met
  logic ms_tick; // one pulse per stamp unit
  logic cyc_tick; // one pulse per evaluation period
  logic [31:0] stamp; // time stamp in ms
  modport host (output m1, m2, m3, t1, t2, t3, prev, cnt, kind, hand,
    input value, pick, ms_tick, cyc_tick, stamp);
  modport comb (input m1, m2, m3, t1, t2, t3, prev, cnt, kind, hand,
    output value, pick);
  modport timer (output ms_tick, cyc_tick, stamp);
endinterface

// ===== verilog/tick_timer.sv
// millisecond time stamp and evaluation period tick
`timescale 1ns/1ps
module tick_timer import stage_pkg::*;
#(
  parameter int MS_CNT = MS_CYCLES // cycles per ms
)
(
  input wire logic ref_clk, // clock
  input wire logic rstn, // sync reset, low active
  input wire logic ce, // clock enable
  stage_link_if.timer lk // ticks and stamp
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [31:0] pre; // cycle prescaler
    logic [2:0] ms5; // ms within the period
    logic [31:0] stamp; // running stamp
    logic ms_t; // ms pulse
    logic cyc_t; // period pulse
  } tstate_t;
  tstate_t r, n;
  // ==========================================================
  // prescale to 1 ms, then to the evaluation period
  always_comb
  begin
    n = r;
    n.ms_t = 1'b0;
    n.cyc_t = 1'b0;
    if (r.pre >= 32'(MS_CNT - 1))
    begin
      n.pre = '0;
      n.ms_t = 1'b1;
      n.stamp = r.stamp + 32'h1; // stamp counts in 1 ms steps
      // period rolls over every five stamps
      if (r.ms5 == CYCLE_MS - 3'h1)
      begin
        n.ms5 = '0;
        n.cyc_t = 1'b1;
      end
      else
        n.ms5 = r.ms5 + 3'h1;
    end
    else
      n.pre = r.pre + 32'h1;
  end
  // registers, frozen while ce is low
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      r <= '0;
    else if (ce)
      r <= n;
  end
  assign lk.ms_tick = r.ms_t;
  assign lk.cyc_tick = r.cyc_t;
  assign lk.stamp = r.stamp;
endmodule // tick_timer

// ===== verilog/magnitude_combiner.sv
// combines up to three magnitudes and tests the pick-up condition
`timescale 1ns/1ps
module magnitude_combiner import stage_pkg::*;
(
  stage_link_if.comb lk // operands in, value and pick-up out
);
  // ==========================================================
  // helpers; values are unsigned 8.8 fixed point
  function automatic logic [15:0] sat(input logic [39:0] v);
    return (|v[39:16]) ? 16'hffff : v[15:0];
  endfunction
  function automatic logic [15:0] mx(input logic [15:0] a, b);
    return (a > b) ? a : b;
  endfunction
  function automatic logic [15:0] mn(input logic [15:0] a, b);
    return (a < b) ? a : b;
  endfunction
  // over or under compare; rate falls back to over for per-signal modes
  function automatic logic hit(input logic [15:0] v, t, logic [1:0] k);
    return (k == KIND_UNDER) ? (v < t) : (v > t);
  endfunction
  logic [15:0] p2; // two-signal product
  logic [15:0] q2; // quotient, saturates on a zero divisor
  logic [15:0] dif; // rate magnitude
  logic h1, h2, h3; // per-signal hits
  assign p2 = sat({8'h00, 32'(lk.m1) * 32'(lk.m2)} >> 8);
  assign q2 = (lk.m2 == 16'h0) ? 16'hffff
    : sat({16'h0, 24'({lk.m1, 8'h00} / lk.m2)});
  assign h1 = hit(lk.m1, lk.t1, lk.kind);
  assign h2 = hit(lk.m2, lk.t2, lk.kind);
  assign h3 = hit(lk.m3, lk.t3, lk.kind);
  assign dif = (lk.value > lk.prev) ? 16'(lk.value - lk.prev)
    : 16'(lk.prev - lk.value);
  // ==========================================================
  // value selection by count and handling code
  always_comb
  begin
    lk.value = lk.m1;
    lk.pick = 1'b0;
    unique case (lk.cnt)
      2'h1:
        unique case (lk.hand)
          3'h0: lk.value = p2;
          3'h1: lk.value = q2;
          3'h2: lk.value = mx(lk.m1, lk.m2);
          3'h3: lk.value = mn(lk.m1, lk.m2);
          3'h4: lk.pick = h1 | h2;
          3'h5: lk.pick = h1 & h2;
          3'h6: lk.value = (lk.m1 > lk.m2) ? 16'(lk.m1 - lk.m2)
            : 16'h0;
          default: lk.value = lk.m1; // unused code acts as one signal
        endcase
      2'h2:
        unique case (lk.hand)
          3'h0: lk.value = sat({8'h00, 32'(p2) * 32'(lk.m3)} >> 8);
          3'h1: lk.value = mx(mx(lk.m1, lk.m2), lk.m3);
          3'h2: lk.value = mn(mn(lk.m1, lk.m2), lk.m3);
          3'h3: lk.pick = h1 | h2 | h3;
          3'h4: lk.pick = h1 & h2 & h3;
          3'h5: lk.pick = (h1 | h2) & h3;
          default: lk.value = lk.m1;
        endcase
      default: lk.value = lk.m1;
    endcase
    // aggregate modes test the combined value
    if (!(lk.cnt == 2'h1 && (lk.hand == 3'h4 || lk.hand == 3'h5)) &&
        !(lk.cnt == 2'h2 && lk.hand >= 3'h3 && lk.hand <= 3'h5))
      lk.pick = (lk.kind == KIND_RATE) ? (dif > lk.t1)
        : hit(lk.value, lk.t1, lk.kind);
  end
endmodule // magnitude_combiner

// ===== verilog/user_stage.sv
// bank of ten programmable threshold stages with an apb register file
// Overview of operation
// - ten stages, each watching one to three magnitudes
// - pick-up on over, under or rate of change
// - definite-time delay after pick-up before trip
// - stages evaluated once every 5 ms
// - available count 1..10; unavailable stages stay disabled
// - per-stage enable; disabled reports disabled condition
// - enabled stage reports condition, operate and remaining time
// - start, trip and blocked outputs per stage
// - eight setting groups, one common group select
// - instant or definite-time delayed operation
// - stamped event on each output edge
// - instant start and trip share one 1 ms stamp
// - resettable start, trip and blocked counters
// - group switch leaves general configuration unchanged
// - operating mode 1..5 with effective mode readback
// - force start, trip or blocked when permitted
// - magnitude count 0, 1, 2 selects one to three
// - two magnitudes: product or quotient
// - two magnitudes: larger value
// - two magnitudes: min, or, and, difference
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module user_stage import stage_pkg::*;
#(
  parameter int MS_CNT = MS_CYCLES // cycles per 1 ms stamp
)
(
  input wire logic ref_clk, // 25 MHz clock
  input wire logic rstn, // sync reset, low active
  input wire logic ce, // clock enable
  input wire logic [7:0] paddr, // apb byte address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic [127:0] mag_bus, // eight 16-bit magnitudes
  input wire logic [9:0] stage_block, // per-stage block inputs
  output logic [9:0] start_o, // start per stage
  output logic [9:0] trip_o, // trip per stage
  output logic [9:0] blocked_o, // blocked per stage
  output logic evt_valid, // event pulse
  output logic [3:0] evt_stage, // stage of the event
  output logic [2:0] evt_chg, // changed outputs {blk, trip, start}
  output logic [2:0] evt_lvl, // new levels {blk, trip, start}
  output logic [31:0] evt_stamp // stamp in ms
);
  // ==========================================================
  // state
  typedef struct packed {
    sweep_t sw; // sweep machine
    logic [3:0] idx; // stage under evaluation
    logic [3:0] avail; // stages available
    logic frc_ok; // forcing permitted
    logic [2:0] grp; // active setting group
    logic [2:0] mode_set; // operating mode as written
    logic [2:0] mode_eff; // effective mode
    logic [3:0] sel_stg; // stage seen through the window
    logic [2:0] sel_grp; // group seen through the window
    logic [9:0][19:0] cfg; // static per-stage configuration
    logic [7:0][9:0][2:0][15:0] thr; // thresholds per group
    logic [7:0][9:0][15:0] dly; // delays per group, in periods
    logic [9:0] start; // start outputs
    logic [9:0] trip; // trip outputs
    logic [9:0] blk; // blocked outputs
    logic [9:0][15:0] elapsed; // periods since pick-up
    logic [9:0][15:0] prev; // last combined value
    logic [9:0][2:0][15:0] cnt; // event counters
    logic [9:0][2:0] cond; // reported condition
    logic [31:0] prdata; // read data
    logic pready; // apb ready
    logic pslverr; // apb error
    logic ev_v; // event pulse
    logic [3:0] ev_s; // event stage
    logic [2:0] ev_c; // event change mask
    logic [2:0] ev_l; // event levels
    logic [31:0] ev_t; // event stamp
  } bank_t;
  bank_t r, n;
  stage_link_if lk();
  // ==========================================================
  // helpers
  // pick one 16-bit channel from the magnitude bus
  function automatic logic [15:0] chan(input logic [127:0] b,
    input logic [2:0] s);
    return b[{s, 4'h0} +: 16];
  endfunction
  // a mapped register offset
  function automatic logic mapped(input logic [7:0] a);
    return a <= A_CBLK && a[1:0] == 2'b00;
  endfunction
  // ==========================================================
  // sub-blocks
  magnitude_combiner u_comb (
    .lk(lk.comb)
  );
  tick_timer #(.MS_CNT(MS_CNT)) u_tick (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .lk(lk.timer)
  );
  // operands for the stage under evaluation
  logic [19:0] cur; // its configuration
  assign cur = r.cfg[r.idx];
  assign lk.m1 = chan(mag_bus, cur[CF_CH1 +: 3]);
  assign lk.m2 = chan(mag_bus, cur[CF_CH2 +: 3]);
  assign lk.m3 = chan(mag_bus, cur[CF_CH3 +: 3]);
  assign lk.t1 = r.thr[r.grp][r.idx][0]; // group picks settings
  assign lk.t2 = r.thr[r.grp][r.idx][1];
  assign lk.t3 = r.thr[r.grp][r.idx][2];
  assign lk.prev = r.prev[r.idx];
  assign lk.cnt = cur[CF_MCNT +: 2];
  assign lk.kind = cur[CF_KIND +: 2];
  assign lk.hand = cur[CF_HND +: 3];
  // ==========================================================
  // next-state logic
  always_comb
  begin
    logic [3:0] k; // stage index
    logic [3:0] s; // window stage
    logic [2:0] g; // window group
    logic [2:0] nl; // new output levels
    logic [2:0] ol; // old output levels
    logic [2:0] chg; // changed outputs
    logic [1:0] frc; // force select
    logic on; // stage live
    logic bl; // stage blocked
    logic [15:0] ne; // next elapsed
    logic [15:0] d; // active delay
    k = r.idx;
    s = r.sel_stg;
    g = r.sel_grp;
    nl = '0;
    ol = '0;
    chg = '0;
    frc = '0;
    on = 1'b0;
    bl = 1'b0;
    ne = '0;
    d = '0;
    n = r;
    n.ev_v = 1'b0;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    // apb setup phase: answer is prepared for the access phase
    if (psel && !penable)
    begin
      n.pready = 1'b1;
      n.pslverr = !mapped(paddr);
      n.prdata = '0;
      unique case (paddr)
        A_CTRL: n.prdata = {13'h0, r.mode_set, 8'h0, r.grp, r.frc_ok,
          r.avail};
        A_STAT: n.prdata = {28'h0, r.sw == SW_RUN, r.mode_eff};
        A_SEL: n.prdata = {25'h0, g, s};
        A_CFG: n.prdata = {12'h0, r.cfg[s]};
        A_THR1: n.prdata = {16'h0, r.thr[g][s][0]};
        A_THR2: n.prdata = {16'h0, r.thr[g][s][1]};
        A_THR3: n.prdata = {16'h0, r.thr[g][s][2]};
        A_DLY: n.prdata = {16'h0, r.dly[g][s]};
        // condition, outputs and remaining time
        A_SSTAT: n.prdata = {
          (r.start[s] && !r.trip[s] && r.cfg[s][CF_DLY])
            ? 16'(r.dly[r.grp][s] - r.elapsed[s]) : 16'h0,
          10'h0, r.blk[s], r.trip[s], r.start[s], r.cond[s]};
        A_OPT: n.prdata = {16'h0, r.cfg[s][CF_DLY]
          ? r.dly[r.grp][s] : 16'h0};
        A_CSTART: n.prdata = {16'h0, r.cnt[s][0]};
        A_CTRIP: n.prdata = {16'h0, r.cnt[s][1]};
        A_CBLK: n.prdata = {16'h0, r.cnt[s][2]};
        default: n.prdata = '0; // unmapped reads zero
      endcase
    end
    // apb access phase: writes land on the completing edge
    if (psel && penable && r.pready && pwrite)
    begin
      unique case (paddr)
        A_CTRL:
        begin
          // only 1..10 is a legal count
          if (pwdata[3:0] != 4'h0 && pwdata[3:0] <= 4'(NSTG))
            n.avail = pwdata[3:0];
          n.frc_ok = pwdata[CTL_FRC];
          n.grp = pwdata[CTL_GRP +: 3]; // common group select
          // illegal mode codes are ignored
          if (pwdata[CTL_MODE +: 3] >= MODE_ON &&
              pwdata[CTL_MODE +: 3] <= MODE_OFF)
          begin
            n.mode_set = pwdata[CTL_MODE +: 3];
            n.mode_eff = pwdata[CTL_MODE +: 3];
          end
          if (pwdata[CTL_CLR])
            n.cnt = '0; // counter reset
        end
        A_SEL:
          if (pwdata[3:0] < 4'(NSTG))
          begin
            n.sel_stg = pwdata[3:0];
            n.sel_grp = pwdata[6:4];
          end
        // static settings, not tied to a group
        A_CFG: n.cfg[s] = pwdata[19:0];
        A_THR1: n.thr[g][s][0] = pwdata[15:0];
        A_THR2: n.thr[g][s][1] = pwdata[15:0];
        A_THR3: n.thr[g][s][2] = pwdata[15:0];
        A_DLY: n.dly[g][s] = pwdata[15:0];
        default: n.pslverr = 1'b0; // read-only or unmapped, ignored
      endcase
    end
    // sweep over the stages, one per cycle, each period
    unique case (r.sw)
      SW_IDLE:
        if (lk.cyc_tick)
        begin
          n.sw = SW_RUN;
          n.idx = '0;
        end
      SW_RUN:
      begin
        frc = cur[CF_FRC +: 2];
        d = r.dly[r.grp][k];
        // available and enabled and not switched off
        on = cur[CF_EN] && k < r.avail && r.mode_eff != MODE_OFF;
        bl = r.mode_eff == MODE_BLK || r.mode_eff == MODE_TBLK ||
          stage_block[k];
        if (!on)
        begin
          nl = 3'b000;
          n.cond[k] = COND_DIS;
        end
        else if (r.frc_ok && frc != 2'h0)
        begin
          // forced levels override evaluation
          nl = {frc == 2'h3, frc == 2'h2, frc == 2'h1};
          n.cond[k] = COND_IDLE + 3'(frc);
        end
        else if (bl)
        begin
          nl = 3'b100; // blocked holds trip low
          n.cond[k] = COND_BLK;
        end
        else if (lk.pick)
        begin
          // delay counts whole periods of pick-up
          ne = (r.elapsed[k] == 16'hffff) ? r.elapsed[k]
            : 16'(r.elapsed[k] + 16'h1);
          // instant mode trips with start
          nl = {1'b0, !cur[CF_DLY] || ne >= d, 1'b1};
          n.cond[k] = nl[1] ? COND_TRIP : COND_START;
        end
        else
        begin
          nl = 3'b000; // pick-up lost, delay restarts
          n.cond[k] = COND_IDLE;
        end
        n.elapsed[k] = ne;
        n.prev[k] = on ? lk.value : r.prev[k];
        ol = {r.blk[k], r.trip[k], r.start[k]};
        chg = nl ^ ol;
        n.start[k] = nl[0];
        n.trip[k] = nl[1];
        n.blk[k] = nl[2];
        // one record carries all edges with one stamp
        if (chg != 3'b000)
        begin
          n.ev_v = 1'b1;
          n.ev_s = k;
          n.ev_c = chg;
          n.ev_l = nl;
          n.ev_t = lk.stamp;
        end
        // rising edges count; applied after a clear so they win
        for (int b = 0; b < 3; b++)
          if (nl[b] && !ol[b])
            n.cnt[k][b] = 16'(n.cnt[k][b] + 16'h1);
        if (k == 4'(NSTG - 1))
          n.sw = SW_IDLE;
        else
          n.idx = 4'(k + 4'h1);
      end
    endcase
  end
  // ==========================================================
  // registers, frozen while ce is low
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      r <= '0;
      r.sw <= SW_IDLE;
      r.avail <= AVAIL_RST;
      r.mode_set <= MODE_ON;
      r.mode_eff <= MODE_ON;
    end
    else if (ce)
      r <= n;
  end
  // outputs straight from the state register
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign start_o = r.start;
  assign trip_o = r.trip;
  assign blocked_o = r.blk;
  assign evt_valid = r.ev_v;
  assign evt_stage = r.ev_s;
  assign evt_chg = r.ev_c;
  assign evt_lvl = r.ev_l;
  assign evt_stamp = r.ev_t;
endmodule // user_stage

// ===== test/stage_chk.sv
// concurrent checks on the pins of the stage bank
`timescale 1ns/1ps
module stage_chk import stage_pkg::*;
#(
  parameter int MS_CNT = MS_CYCLES // cycles per ms
)
(
  input wire logic ref_clk, // clock
  input wire logic rstn, // sync reset, low active
  input wire logic ce, // clock enable
  input wire logic [7:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic [9:0] start_o, // start per stage
  input wire logic [9:0] trip_o, // trip per stage
  input wire logic [9:0] blocked_o, // blocked per stage
  input wire logic evt_valid, // event pulse
  input wire logic [2:0] evt_chg // changed outputs
);
  // ==========================================================
  // one clock domain, so one default clocking and reset
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire logic [29:0] outs = {start_o, trip_o, blocked_o}; // all stage pins
  // apb answer: one wait-free access cycle, error only when unmapped
  a_ready_setup: assert property (psel && !penable && ce |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready && ce |=> !pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (psel && !penable && ce
    && (paddr > 8'h30 || paddr[1:0] != 2'h0) |=> pslverr)
    else $error("unmapped access without error");
  a_err_mapped: assert property (psel && !penable && ce
    && paddr <= 8'h30 && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("error on mapped access");
  // ==========================================================
  // stage outputs and their event records
  a_blk_no_trip: assert property ((blocked_o & trip_o) == 10'h0)
    else $error("trip while blocked");
  a_blk_no_start: assert property ((blocked_o & start_o) == 10'h0)
    else $error("start while blocked");
  a_evt_on_edge: assert property (!$stable(outs) |-> evt_valid)
    else $error("output edge without event");
  a_evt_has_chg: assert property (evt_valid |-> evt_chg != 3'h0)
    else $error("event without change");
  // a frozen clock enable must hold the stage pins and the read data
  a_ce_freeze: assert property (!ce |=> $stable(outs) && $stable(prdata))
    else $error("outputs moved with clock enable low");
  a_reset_clear: assert property (disable iff (1'b0)
    !rstn && ce |=> outs == 30'h0 && !pready && !evt_valid)
    else $error("outputs not cleared by reset");
  c_trip: cover property ($rose(trip_o[0]));
  c_blocked: cover property ($rose(blocked_o[0]));
  c_slverr: cover property (pready && pslverr);
endmodule // stage_chk
bind user_stage stage_chk #(.MS_CNT(MS_CNT)) chk_u (.ref_clk(ref_clk),
  .rstn(rstn), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .start_o(start_o),
  .trip_o(trip_o), .blocked_o(blocked_o), .evt_valid(evt_valid),
  .evt_chg(evt_chg));

// ===== test/mag_source.sv
// model of the measurement pre-processing feeding the stage bank
`timescale 1ns/1ps
module mag_source
(
  input wire logic ref_clk, // clock
  input logic [15:0] mag_set [8], // wanted value per channel
  output logic [127:0] mag_bus // published magnitudes
);
  // ==========================================================
  // values are published one refresh after they are asked for
  always_ff @(posedge ref_clk)
    for (int c = 0; c < 8; c++)
      mag_bus[16*c +: 16] <= mag_set[c];
endmodule // mag_source

// ===== test/tb_user_stage.sv
// self-checking bench for the threshold stage bank
`timescale 1ns/1ps
module tb_user_stage import stage_pkg::*; ;
  // ==========================================================
  // signals, notes and tallies
  logic ref_clk, rstn, ce, psel, penable, pwrite; // bench driven
  logic [7:0] paddr; // apb address
  logic [31:0] pwdata, prdata, seed, evt_stamp, t0; // apb, rng, stamps
  logic pready, pslverr, evt_valid; // dut answers
  logic [9:0] stage_block, start_o, trip_o, blocked_o; // stage pins
  logic [3:0] evt_stage; // event stage
  logic [2:0] evt_chg, evt_lvl; // event fields
  logic [127:0] mag_bus; // magnitudes
  logic [15:0] mag_set [8]; // wanted magnitudes
  logic [64:0] note_q [$]; // {data, mask, err} per read
  int error_cnt, check_count; // tallies
  localparam logic [6:0] PAT = 7'h56; // pick-up per handling code
  mag_source src_u (.ref_clk(ref_clk), .mag_set(mag_set),
    .mag_bus(mag_bus));
  // short period: 20 cycles per evaluation
  user_stage #(.MS_CNT(4)) dut_u (.ref_clk(ref_clk), .rstn(rstn), .ce(ce),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mag_bus(mag_bus), .stage_block(stage_block), .start_o(start_o),
    .trip_o(trip_o), .blocked_o(blocked_o), .evt_valid(evt_valid),
    .evt_stage(evt_stage), .evt_chg(evt_chg), .evt_lvl(evt_lvl),
    .evt_stamp(evt_stamp));
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  // request held until pready is seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] m, input logic err);
    if (!w)
      note_q.push_back({d, m, err});
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (!pready);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, e, m, 1'b0);
  endtask
  task cfg(input logic [31:0] v);
    wr(A_CFG, v);
    repeat (45) @(negedge ref_clk);
  endtask
  task wait_evt(input logic [2:0] lvl);
    do @(negedge ref_clk); while (!(evt_valid && evt_stage == 4'h0));
    chk("evt_lvl", {29'h0, lvl}, {29'h0, evt_lvl});
  endtask
  task delay_run();
    wait_evt(3'h1);
    t0 = evt_stamp;
    repeat (59) @(negedge ref_clk);
    chk("early trip", 32'h0, {31'h0, trip_o[0]});
    @(negedge ref_clk);
    chk("trip", 32'h1, {31'h0, trip_o[0]});
    chk("stamp", t0 + 32'(CYCLE_MS) * 32'h3, evt_stamp);
  endtask
  task tally_and_finish();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // read monitor: oldest note against each read answer
  always @(posedge ref_clk)
    if (psel && penable && pready && !pwrite)
    begin
      chk("prdata", note_q[0][64:33], prdata & note_q[0][32:1]);
      chk("pslverr", {31'h0, note_q[0][0]}, {31'h0, pslverr});
      void'(note_q.pop_front());
    end
  // watchdog against a hang
  initial
  begin
    repeat (10000) @(posedge ref_clk);
    error_cnt++;
    tally_and_finish();
  end
  // ==========================================================
  // main sequence
  initial
  begin
    seed = 32'h242f;
    {rstn, psel, penable, pwrite, paddr, pwdata, stage_block} = '0;
    ce = 1'b1;
    error_cnt = 0;
    check_count = 0;
    for (int c = 0; c < 8; c++)
      mag_set[c] = 16'(xs());
    mag_set[0] = 16'h0000;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    ce <= 1'b0;
    repeat (2) @(posedge ref_clk);
    ce <= 1'b1;
    rd(A_CTRL, 32'h00010001, 32'hffffffff);
    apb(1'b0, 8'h34, 32'h0, 32'h0, 1'b1);
    rd(A_SSTAT, 32'h0, 32'h7);
    for (int m = 1; m < 6; m++)
    begin
      wr(A_CTRL, 32'h1 | (32'(m) << 16));
      rd(A_STAT, 32'(m), 32'h7);
    end
    wr(A_CTRL, 32'h00010001);
    wr(A_THR1, 32'h0170);
    wr(A_CFG, 32'h1);
    @(posedge ref_clk);
    mag_set[0] <= 16'h0200 | (16'(xs()) & 16'h00ff);
    wait_evt(3'h3);
    chk("evt_chg", 32'h3, {29'h0, evt_chg});
    rd(A_CTRIP, 32'h1, 32'hffff);
    wr(A_CTRL, 32'h00010101);
    rd(A_CSTART, 32'h0, 32'hffff);
    stage_block <= 10'h1;
    wait_evt(3'h4);
    rd(A_CBLK, 32'h1, 32'hffff);
    stage_block <= 10'h0;
    wait_evt(3'h3);
    mag_set[0] <= 16'h0000;
    wait_evt(3'h0);
    wr(A_DLY, 32'h4);
    wr(A_CFG, 32'h401);
    rd(A_OPT, 32'h4, 32'hffff);
    mag_set[0] <= 16'h0200;
    delay_run();
    mag_set[0] <= 16'h0000;
    wait_evt(3'h0);
    mag_set[0] <= 16'h0200;
    delay_run();
    mag_set[1] <= 16'h0080;
    wr(A_THR2, 32'h0100);
    for (int h = 0; h < 7; h++)
    begin
      cfg(32'h4009 | (32'(h) << 5));
      chk("pick", {31'h0, PAT[h]}, {31'h0, start_o[0]});
    end
    cfg(32'h0901);
    chk("under", 32'h1, {31'h0, start_o[0]});
    wr(A_CTRL, 32'h00010011);
    for (int f = 1; f < 4; f++)
    begin
      cfg(32'h1 | (32'(f) << 1));
      chk("force", 32'(1 << (f - 1)),
        {29'h0, blocked_o[0], trip_o[0], start_o[0]});
    end
    wr(A_CTRL, 32'h00010001);
    cfg(32'h1);
    wr(A_SEL, 32'h10);
    wr(A_THR1, 32'hffff);
    wr(A_SEL, 32'h0);
    wr(A_CTRL, 32'h00010021);
    repeat (45) @(negedge ref_clk);
    chk("group", 32'h0, {31'h0, start_o[0]});
    rd(A_CFG, 32'h1, 32'hfffff);
    repeat (4) @(posedge ref_clk);
    tally_and_finish();
  end
endmodule // tb_user_stage
